// file: timer_and_watchdog_unit.sv
/*
 * Four 64-bit prescaled up/down timers and three four-stage watchdogs
 * behind a classic Wishbone slave (32-bit, word addressed).
 * Assumes one 50 MHz clock, synchronous active-high reset, and that
 * boot_from_flash_i is stable when reset is released.
 */
// Functional notes
// - four timers exist, each a 64-bit counter fed by a 16-bit prescaler.
// - each prescaler divides by any ratio from 2 to 65536.
// - each counter counts up or down on every prescaled tick.
// - a timer can be halted and resumed keeping its count.
// - alarm may auto-reload the counter, and software may reload anytime.
// - a timer alarm is signalled as a level or as a one-cycle pulse.
// - there are three watchdogs, two main ones and one low-power one.
// - each watchdog walks four stages, firing actions unless fed or off.
// - a stage action is interrupt, processor, core or system reset.
// - only the low-power watchdog may pick the whole-system reset.
// - each stage has its own timeout and may be disabled on its own.
// - on flash boot the low-power and first main watchdog start alone.
// - watchdog settings are write-protected until a key unlocks them.
// - a flash boot that overruns its period reboots the whole system.
`timescale 1ns/100ps
module timer_and_watchdog_unit
   import tw_pkg::*;
#(
   parameter int BOOT_CYC = BOOT_TMO_CYC
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   input  wire logic                  we_i,
   input  wire logic [9:0]            adr_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic [31:0]           dat_i,
   output logic      [31:0]           dat_o,
   output logic                       ack_o,
   input  wire logic                  boot_from_flash_i,
   output logic      [NUM_TIMERS-1:0] timer_irq_o,
   output logic      [NUM_WDOGS-1:0]  wdog_irq_o,
   output logic                       cpu_reset_o,
   output logic                       core_reset_o,
   output logic                       system_reset_o
);
   typedef enum logic [1:0] {BUS_IDLE, BUS_PEND, BUS_ACK} bus_st_t;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   bus_st_t     bus_q;
   logic        req;
   logic        wr;
   logic [7:0]  idx;
   logic        hit_t;
   logic        hit_w;
   logic        hit_m;
   logic [1:0]  sel_t;
   logic [1:0]  sel_w;
   logic [31:0] rd_d;

   assign idx   = adr_i[9:2];
   assign req   = cyc_i & stb_i & (bus_q == BUS_IDLE);
   assign wr    = (bus_q == BUS_ACK) & cyc_i & stb_i & we_i;
   assign hit_t = idx[7:5] == AREA_TIMER;
   assign sel_t = idx[4:3];
   assign sel_w = idx[3:2];
   assign hit_w = (idx[7:4] == AREA_WDOG) & (sel_w != 2'h3);
   assign hit_m = (idx[7:4] == AREA_WTMO) & (sel_w != 2'h3);

   // two-cycle answer: request, then memory read settles, then ack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_q <= BUS_IDLE;
         ack_o <= 1'b0;
      end
      else
      begin
         case (bus_q)
            BUS_IDLE:
            begin
               ack_o <= 1'b0;
               if (req)
               begin
                  bus_q <= BUS_PEND;
               end
            end
            BUS_PEND:
            begin
               bus_q <= BUS_ACK;
               ack_o <= 1'b1;
            end
            BUS_ACK:
            begin
               bus_q <= BUS_IDLE;
               ack_o <= 1'b0;
            end
            default:
            begin
               bus_q <= BUS_IDLE;
               ack_o <= 1'b0;
            end
         endcase
      end
   end

   // timers
   logic [31:0] tcfg_q  [NUM_TIMERS];
   logic [63:0] load_q  [NUM_TIMERS];
   logic [63:0] alarm_q [NUM_TIMERS];
   logic [63:0] cnt_q   [NUM_TIMERS];
   logic [31:0] snap_q  [NUM_TIMERS];
   logic [15:0] div_q   [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] tst_q;

   genvar t;
   generate
      for (t = 0; t < NUM_TIMERS; t++)
      begin : g_tmr
         logic        wsel;
         logic [15:0] ratio_m1;
         logic        tick;
         logic        evt;
         logic        swload;
         logic        clr;
         assign wsel = wr & hit_t & (sel_t == 2'(t));
         assign swload = wsel & (idx[2:0] == T_CTRL) & dat_i[TK_RELOAD];
         assign clr = wsel & (idx[2:0] == T_CTRL) & dat_i[TK_CLR];
         // 0 selects 65536, 1 is raised to the least ratio of 2
         assign ratio_m1 =
            (tcfg_q[t][31:16] == 16'h0000) ? DIV_MAX_M1 :
            (tcfg_q[t][31:16] == 16'h0001) ? DIV_MIN_M1 :
            tcfg_q[t][31:16] - 16'h0001;
         assign tick = tcfg_q[t][TC_EN] & (div_q[t] == ratio_m1);
         assign evt = tick & tcfg_q[t][TC_ALARM] & (cnt_q[t] == alarm_q[t]);

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               tcfg_q[t]  <= TCFG_RST;
               load_q[t]  <= 64'h0;
               alarm_q[t] <= 64'h0;
            end
            else if (wsel)
            begin
               case (idx[2:0])
                  T_CFG:      tcfg_q[t] <= merge(tcfg_q[t], dat_i, sel_i);
                  T_LOAD_LO:  load_q[t][31:0] <=
                                 merge(load_q[t][31:0], dat_i, sel_i);
                  T_LOAD_HI:  load_q[t][63:32] <=
                                 merge(load_q[t][63:32], dat_i, sel_i);
                  T_ALARM_LO: alarm_q[t][31:0] <=
                                 merge(alarm_q[t][31:0], dat_i, sel_i);
                  T_ALARM_HI: alarm_q[t][63:32] <=
                                 merge(alarm_q[t][63:32], dat_i, sel_i);
                  default:    tcfg_q[t] <= tcfg_q[t];
               endcase
            end
         end

         // prescaler frozen while halted, so resume keeps the phase
         always_ff @(posedge clk_i)
         begin
            if (rst_i | tick)
            begin
               div_q[t] <= 16'h0000;
            end
            else if (tcfg_q[t][TC_EN])
            begin
               div_q[t] <= div_q[t] + 16'h0001;
            end
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               cnt_q[t] <= 64'h0;
            end
            else if (swload)
            begin
               cnt_q[t] <= load_q[t];
            end
            else if (evt & tcfg_q[t][TC_AUTO])
            begin
               cnt_q[t] <= load_q[t];
            end
            else if (tick)
            begin
               cnt_q[t] <= tcfg_q[t][TC_UP] ? cnt_q[t] + 64'h1
                                           : cnt_q[t] - 64'h1;
            end
         end

         // reading the low word freezes the high word for a coherent pair
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               snap_q[t] <= 32'h0;
            end
            else if ((bus_q == BUS_PEND) & hit_t & (sel_t == 2'(t))
                     & (idx[2:0] == T_CNT_LO))
            begin
               snap_q[t] <= cnt_q[t][63:32];
            end
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               tst_q[t]       <= 1'b0;
               timer_irq_o[t] <= 1'b0;
            end
            else
            begin
               tst_q[t] <= evt | (tst_q[t] & ~clr);
               timer_irq_o[t] <= tcfg_q[t][TC_EDGE] ? evt
                                 : (evt | (tst_q[t] & ~clr));
            end
         end
      end
   endgenerate

   // watchdogs
   logic [31:0] wcfg_q [NUM_WDOGS];
   logic [31:0] wcnt_q [NUM_WDOGS];
   logic [31:0] wtmo_q [NUM_WDOGS];
   logic [1:0]  wstg_q [NUM_WDOGS];
   logic [1:0]  tstg_q [NUM_WDOGS];
   logic [NUM_WDOGS-1:0] tok_q;
   logic [NUM_WDOGS-1:0] lock_q;
   logic [NUM_WDOGS-1:0] boot_q;
   logic [NUM_WDOGS-1:0] fire_cpu;
   logic [NUM_WDOGS-1:0] fire_core;
   logic [NUM_WDOGS-1:0] fire_sys;
   logic        boot_seen_q;
   logic [1:0]  scan_q;
   logic        scan_v_q;
   logic [1:0]  scan_id_q;
   logic [1:0]  scan_stg_q;
   logic        ram_we;
   logic        ram_bus_rd;
   logic [3:0]  ram_raddr;
   logic [31:0] ram_rdata;

   assign ram_we     = wr & hit_m & ~lock_q[sel_w];
   assign ram_bus_rd = req & hit_m;
   assign ram_raddr  = ram_bus_rd ? idx[3:0] : {scan_q, wstg_q[scan_q]};

   wd_timeout_ram #(
      .DW (32),
      .AW (4)
   ) u_tmo_ram (
      .clk_i   (clk_i),
      .we_i    (ram_we),
      .waddr_i (idx[3:0]),
      .wdata_i (dat_i),
      .raddr_i (ram_raddr),
      .rdata_o (ram_rdata)
   );

   // timeouts are fetched round-robin into per-watchdog copies
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scan_q     <= 2'h0;
         scan_v_q   <= 1'b0;
         scan_id_q  <= 2'h0;
         scan_stg_q <= 2'h0;
      end
      else
      begin
         scan_v_q   <= ~ram_bus_rd & ~ram_we;
         scan_id_q  <= scan_q;
         scan_stg_q <= wstg_q[scan_q];
         if (~ram_bus_rd)
         begin
            scan_q <= (scan_q == 2'(NUM_WDOGS - 1)) ? 2'h0
                                                    : scan_q + 2'h1;
         end
      end
   end

   // strap caught on the first clock after reset release
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         boot_seen_q <= 1'b0;
      end
      else
      begin
         boot_seen_q <= 1'b1;
      end
   end

   genvar w;
   generate
      for (w = 0; w < NUM_WDOGS; w++)
      begin : g_wd
         logic       wsel;
         logic       feed;
         logic       cfgw;
         logic       expire;
         logic [2:0] act;
         logic [2:0] bact;
         assign wsel = wr & hit_w & (sel_w == 2'(w));
         assign feed = wsel & (idx[1:0] == W_FEED);
         assign cfgw = wsel & (idx[1:0] == W_CFG) & ~lock_q[w];
         assign bact = (w == LP_WDOG) ? ACT_SYS : ACT_CORE;
         assign act = boot_q[w] ? bact
                    : wcfg_q[w][WC_ACT_LSB + WC_ACT_STEP*wstg_q[w] +: 3];
         assign expire = wcfg_q[w][WC_EN] & (boot_q[w]
                  ? (wcnt_q[w] >= 32'(BOOT_CYC))
                  : (tok_q[w] & (tstg_q[w] == wstg_q[w])
                     & (wcnt_q[w] >= wtmo_q[w])));
         assign fire_cpu[w]  = expire & (act == ACT_CPU);
         assign fire_core[w] = expire & (act == ACT_CORE);
         // a main watchdog set to system reset does nothing
         assign fire_sys[w]  = expire & (act == ACT_SYS)
                             & (w == LP_WDOG);

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               wcfg_q[w] <= WCFG_RST;
               boot_q[w] <= 1'b0;
            end
            else if (~boot_seen_q)
            begin
               if (boot_from_flash_i & (w != 1))
               begin
                  wcfg_q[w][WC_EN] <= 1'b1;
                  boot_q[w]        <= 1'b1;
               end
            end
            else if (cfgw)
            begin
               wcfg_q[w] <= merge(wcfg_q[w], dat_i, sel_i);
               boot_q[w] <= 1'b0;
            end
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               lock_q[w] <= 1'b1;
            end
            else if (wsel & (idx[1:0] == W_PROT))
            begin
               lock_q[w] <= (dat_i != WDOG_KEY);
            end
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               tok_q[w]  <= 1'b0;
               wtmo_q[w] <= 32'h0;
               tstg_q[w] <= 2'h0;
            end
            else if (ram_we)
            begin
               tok_q[w] <= 1'b0;
            end
            else if (scan_v_q & (scan_id_q == 2'(w)))
            begin
               tok_q[w]  <= 1'b1;
               wtmo_q[w] <= ram_rdata;
               tstg_q[w] <= scan_stg_q;
            end
         end

         // stage code zero lets the stage pass silently
         always_ff @(posedge clk_i)
         begin
            if (rst_i | feed | cfgw | ~wcfg_q[w][WC_EN])
            begin
               wcnt_q[w] <= 32'h0;
               wstg_q[w] <= 2'h0;
            end
            else if (expire)
            begin
               wcnt_q[w] <= 32'h0;
               wstg_q[w] <= boot_q[w] ? 2'h0 : wstg_q[w] + 2'h1;
            end
            else
            begin
               wcnt_q[w] <= wcnt_q[w] + 32'h1;
            end
         end

         // interrupt level held until the next feed; new expiry wins
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               wdog_irq_o[w] <= 1'b0;
            end
            else
            begin
               wdog_irq_o[w] <= (expire & (act == ACT_IRQ))
                              | (wdog_irq_o[w] & ~feed);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cpu_reset_o    <= 1'b0;
         core_reset_o   <= 1'b0;
         system_reset_o <= 1'b0;
      end
      else
      begin
         cpu_reset_o    <= |fire_cpu;
         core_reset_o   <= |fire_core;
         system_reset_o <= |fire_sys;
      end
   end

   always_comb
   begin
      rd_d = 32'h0;
      if (hit_t)
      begin
         case (idx[2:0])
            T_CFG:      rd_d = tcfg_q[sel_t];
            T_LOAD_LO:  rd_d = load_q[sel_t][31:0];
            T_LOAD_HI:  rd_d = load_q[sel_t][63:32];
            T_ALARM_LO: rd_d = alarm_q[sel_t][31:0];
            T_ALARM_HI: rd_d = alarm_q[sel_t][63:32];
            T_CNT_LO:   rd_d = cnt_q[sel_t][31:0];
            T_CNT_HI:   rd_d = snap_q[sel_t];
            T_CTRL:     rd_d = {31'h0, tst_q[sel_t]};
            default:    rd_d = 32'h0;
         endcase
      end
      else if (hit_w)
      begin
         case (idx[1:0])
            W_CFG:   rd_d = wcfg_q[sel_w];
            W_STAT:
            begin
               rd_d[1:0]     = wstg_q[sel_w];
               rd_d[WS_BOOT] = boot_q[sel_w];
               rd_d[WS_IRQ]  = wdog_irq_o[sel_w];
               rd_d[WS_LOCK] = lock_q[sel_w];
            end
            default: rd_d = 32'h0;
         endcase
      end
      else if (hit_m)
      begin
         rd_d = ram_rdata;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dat_o <= 32'h0;
      end
      else if ((bus_q == BUS_PEND) & ~we_i)
      begin
         dat_o <= rd_d;
      end
   end
endmodule : timer_and_watchdog_unit

// file: tw_pkg.sv
/*
 * Shared constants of the timer and watchdog unit: register word
 * indices, field positions, reset values and timing figures.
 * Assumes a 50 MHz system clock and a 32-bit Wishbone slave port.
 */
package tw_pkg;
   localparam int          NUM_TIMERS  = 4;
   localparam int          NUM_WDOGS   = 3;
   localparam int          LP_WDOG     = 2;
   localparam int          CLK_HZ      = 50_000_000;
   // word index map (byte address = index * 4)
   localparam logic [2:0]  AREA_TIMER  = 3'h0;
   localparam logic [3:0]  AREA_WDOG   = 4'h2;
   localparam logic [3:0]  AREA_WTMO   = 4'h3;
   localparam logic [2:0]  T_CFG       = 3'h0;
   localparam logic [2:0]  T_LOAD_LO   = 3'h1;
   localparam logic [2:0]  T_LOAD_HI   = 3'h2;
   localparam logic [2:0]  T_ALARM_LO  = 3'h3;
   localparam logic [2:0]  T_ALARM_HI  = 3'h4;
   localparam logic [2:0]  T_CNT_LO    = 3'h5;
   localparam logic [2:0]  T_CNT_HI    = 3'h6;
   localparam logic [2:0]  T_CTRL      = 3'h7;
   localparam logic [1:0]  W_CFG       = 2'h0;
   localparam logic [1:0]  W_FEED      = 2'h1;
   localparam logic [1:0]  W_PROT      = 2'h2;
   localparam logic [1:0]  W_STAT      = 2'h3;
   // timer config fields
   localparam int          TC_EN       = 0;
   localparam int          TC_UP       = 1;
   localparam int          TC_AUTO     = 2;
   localparam int          TC_ALARM    = 3;
   localparam int          TC_EDGE     = 4;
   localparam int          TC_DIV_LSB  = 16;
   localparam int          TK_RELOAD   = 0;
   localparam int          TK_CLR      = 1;
   localparam logic [31:0] TCFG_RST    = 32'h0000_0000;
   // watchdog config fields
   localparam int          WC_EN       = 0;
   localparam int          WC_ACT_LSB  = 4;
   localparam int          WC_ACT_STEP = 4;
   localparam logic [31:0] WCFG_RST    = 32'h0000_0000;
   localparam logic [31:0] WDOG_KEY    = 32'h5A5A_C3C3;
   localparam int          WS_BOOT     = 4;
   localparam int          WS_IRQ      = 8;
   localparam int          WS_LOCK     = 9;
   // stage actions
   localparam logic [2:0]  ACT_NONE    = 3'h0;
   localparam logic [2:0]  ACT_IRQ     = 3'h1;
   localparam logic [2:0]  ACT_CPU     = 3'h2;
   localparam logic [2:0]  ACT_CORE    = 3'h3;
   localparam logic [2:0]  ACT_SYS     = 3'h4;
   // boot guard period
   localparam int          BOOT_TMO_MS  = 1000;
   localparam int          BOOT_TMO_CYC = BOOT_TMO_MS * (CLK_HZ / 1000);
   localparam logic [15:0] DIV_MAX_M1  = 16'hFFFF;
   localparam logic [15:0] DIV_MIN_M1  = 16'h0001;
endpackage : tw_pkg

// file: wd_timeout_ram.sv
/*
 * Small simple dual-port memory holding watchdog stage timeouts.
 * One write port, one read port with registered read data; no reset,
 * contents are undefined until software writes them.
 */
`timescale 1ns/100ps
module wd_timeout_ram #(
   parameter int DW = 32,
   parameter int AW = 4
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_q [2**AW];

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      rdata_o <= mem_q[raddr_i];
   end
endmodule : wd_timeout_ram

// file: tw_properties.sv
/* Checker for the timer and watchdog unit: bus timing, reset pulses,
   irq clearing and the boot guard. Sees only the top ports; the bind
   stands at the foot. */
`timescale 1ns/100ps
module tw_properties
   import tw_pkg::*;
#(
   parameter int BOOT_CYC = 50
) (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  cyc_i,
   input wire logic                  stb_i,
   input wire logic                  we_i,
   input wire logic [9:0]            adr_i,
   input wire logic [3:0]            sel_i,
   input wire logic [31:0]           dat_i,
   input wire logic [31:0]           dat_o,
   input wire logic                  ack_o,
   input wire logic                  boot_from_flash_i,
   input wire logic [NUM_TIMERS-1:0] timer_irq_o,
   input wire logic [NUM_WDOGS-1:0]  wdog_irq_o,
   input wire logic                  cpu_reset_o,
   input wire logic                  core_reset_o,
   input wire logic                  system_reset_o
);
   logic        rel_q;
   logic        boot_q;
   logic [31:0] bcnt_q;
   logic        wd2_cfg;
   // a write to the low-power watchdog config ends its boot mode
   assign wd2_cfg = ack_o && we_i && adr_i[9:2] == 8'h28;
   always_ff @(posedge clk_i)
   begin
      rel_q <= rst_i;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || wd2_cfg)
         boot_q <= 1'b0;
      else if (rel_q)
         boot_q <= boot_from_flash_i;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || system_reset_o || !boot_q)
         bcnt_q <= 32'h0;
      else
         bcnt_q <= bcnt_q + 32'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_time; $rose(cyc_i && stb_i) |-> ##[1:3] ack_o;
   endproperty
   a_ack_time: assert property (p_ack_time) else $error("ack late");
   property p_ack_held; ack_o |-> cyc_i && stb_i; endproperty
   a_ack_held: assert property (p_ack_held) else $error("stray ack");
   property p_rst_quiet;
      disable iff (1'b0) rst_i |=> !ack_o && timer_irq_o == '0 &&
         wdog_irq_o == '0 && !cpu_reset_o && !system_reset_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("reset busy");
   property p_sys_pulse; system_reset_o |=> !system_reset_o; endproperty
   a_sys_pulse: assert property (p_sys_pulse) else $error("sys long");
   property p_core_pulse; core_reset_o |=> !core_reset_o; endproperty
   a_core_pulse: assert property (p_core_pulse) else $error("core");
   property p_cpu_pulse; cpu_reset_o |=> !cpu_reset_o; endproperty
   a_cpu_pulse: assert property (p_cpu_pulse) else $error("cpu long");
   property p_irq_feed; $fell(|wdog_irq_o) |->
      $past(ack_o && we_i) || $past(ack_o && we_i, 2); endproperty
   a_irq_feed: assert property (p_irq_feed) else $error("irq lost");
   property p_boot_bound; bcnt_q <= BOOT_CYC + 8; endproperty
   a_boot_bound: assert property (p_boot_bound) else $error("boot");
   c_read: cover property (ack_o && !we_i);
   c_wirq: cover property (|wdog_irq_o);
   c_sys: cover property (system_reset_o);
endmodule : tw_properties

bind timer_and_watchdog_unit tw_properties #(.BOOT_CYC(BOOT_CYC))
   i_tw_properties (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .boot_from_flash_i(boot_from_flash_i), .timer_irq_o(timer_irq_o),
   .wdog_irq_o(wdog_irq_o), .cpu_reset_o(cpu_reset_o),
   .core_reset_o(core_reset_o), .system_reset_o(system_reset_o));

// file: tb_top.sv
/* Testbench: timers, watchdogs and boot guard of the unit driven over
   Wishbone. Assumes the boot period shortened to 50 cycles. */
`timescale 1ns/100ps
module tb_top;
   import tw_pkg::*;
   logic                  clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
   logic                  boot_from_flash_i, cpu_reset_o;
   logic                  core_reset_o, system_reset_o;
   logic [9:0]            adr_i;
   logic [3:0]            sel_i;
   logic [31:0]           dat_i, dat_o, q, q1, lfsr_q;
   logic [NUM_TIMERS-1:0] timer_irq_o;
   logic [NUM_WDOGS-1:0]  wdog_irq_o;
   int num_errors, compares, cyc_n, n_cpu, n_core, n_sys, al, k, c0, k0;
   int s0;
   timer_and_watchdog_unit #(.BOOT_CYC(50)) i_timer_and_watchdog_unit (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .boot_from_flash_i(boot_from_flash_i),
      .timer_irq_o(timer_irq_o), .wdog_irq_o(wdog_irq_o),
      .cpu_reset_o(cpu_reset_o), .core_reset_o(core_reset_o),
      .system_reset_o(system_reset_o));
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic give_verdict();
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   always @(posedge clk_i)
   begin
      cyc_n++;
      n_cpu += int'(cpu_reset_o === 1'b1);
      n_core += int'(core_reset_o === 1'b1);
      n_sys += int'(system_reset_o === 1'b1);
      if (cyc_n == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction : rnd
   function automatic logic [7:0] tr(input int t, input logic [2:0] r);
      return {2'b00, 3'(t), r};
   endfunction : tr
   function automatic logic [7:0] wa(input int w, input logic [1:0] r);
      return 8'h20 + 8'(4 * w) + {6'h00, r};
   endfunction : wa
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chkb(input string nm, input logic e, g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask : chkb
   // request held until ack is sampled, released on that same edge
   task automatic bus(input logic w, input logic [7:0] wi, logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {wi, 2'b00};
      dat_i <= d;
      sel_i <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] wi, input logic [31:0] d);
      bus(1'b1, wi, d);
   endtask : wr
   task automatic rd(input logic [7:0] wi);
      bus(1'b0, wi, 32'h0);
   endtask : rd
   task automatic rst_dut(input logic b);
      boot_from_flash_i <= b;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : rst_dut
   // timeouts must all be written: the stage memory has no reset
   task automatic wd_setup(input int w, input logic [31:0] tmo, cfg);
      wr(wa(w, W_PROT), WDOG_KEY);
      for (int s = 0; s < 4; s++)
         wr(8'h30 + 8'(4 * w + s), tmo);
      wr(wa(w, W_CFG), cfg);
   endtask : wd_setup
   initial
   begin
      {rst_i, cyc_i, stb_i, we_i, boot_from_flash_i} = 5'h10;
      adr_i = 10'h000;
      sel_i = 4'h0;
      dat_i = 32'h0;
      lfsr_q = 32'h88AAA890;
      rst_dut(1'b0);
      rd(tr(0, T_CFG));
      chk("timer cfg", TCFG_RST, q);
      rd(wa(0, W_STAT));
      chkb("lock", 1'b1, q[WS_LOCK]);
      rd(8'hFF);
      chk("unmapped", 32'h0, q);
      for (int t = 0; t < NUM_TIMERS; t++)
      begin
         al = 4 + int'(rnd() & 32'h7);
         wr(tr(t, T_LOAD_LO), 32'h0);
         wr(tr(t, T_LOAD_HI), 32'h0);
         wr(tr(t, T_ALARM_LO), 32'(al));
         wr(tr(t, T_ALARM_HI), 32'h0);
         wr(tr(t, T_CTRL), 32'h1);
         wr(tr(t, T_CFG), {16'h0002, 11'h0, t[0], 4'hF});
         k = 0;
         while (timer_irq_o[t] !== 1'b1 && k < 300)
         begin
            @(posedge clk_i);
            k++;
         end
         chkb("alarm time", 1'b1, k >= 2 * al - 2 && k <= 2 * al + 8);
         @(posedge clk_i);
         chkb("irq shape", !t[0], timer_irq_o[t]);
         rd(tr(t, T_CTRL));
         chkb("alarm status", 1'b1, q[0]);
         rd(tr(t, T_CNT_LO));
         chkb("auto reload", 1'b1, q <= 32'(al));
         wr(tr(t, T_CFG), 32'h0);
         wr(tr(t, T_CTRL), 32'h2);
         rd(tr(t, T_CTRL));
         chkb("status clear", 1'b0, q[0]);
         chkb("irq clear", 1'b0, timer_irq_o[t]);
      end
      wr(tr(2, T_LOAD_LO), 32'h3E8);
      wr(tr(2, T_CTRL), 32'h1);
      wr(tr(2, T_CFG), 32'h0005_0001);
      rd(tr(2, T_CNT_LO));
      q1 = q;
      repeat (100) @(posedge clk_i);
      rd(tr(2, T_CNT_LO));
      chkb("divide", 1'b1, q1 - q >= 32'h13 && q1 - q <= 32'h17);
      wr(tr(2, T_CFG), 32'h0005_0000);
      rd(tr(2, T_CNT_LO));
      q1 = q;
      repeat (40) @(posedge clk_i);
      rd(tr(2, T_CNT_LO));
      chk("held count", q1, q);
      wr(tr(2, T_CFG), 32'h0005_0001);
      repeat (40) @(posedge clk_i);
      rd(tr(2, T_CNT_LO));
      chkb("resumed", 1'b1, q < q1 && q1 - q <= 32'hB);
      wr(tr(2, T_CTRL), 32'h1);
      rd(tr(2, T_CNT_LO));
      chkb("instant reload", 1'b1, q >= 32'h3E6 && q <= 32'h3E8);
      wr(tr(2, T_CFG), 32'h0);
      wd_setup(0, 32'h28, 32'h11);
      repeat (6)
      begin
         repeat (20) @(posedge clk_i);
         wr(wa(0, W_FEED), 32'h0);
      end
      chkb("fed", 1'b0, wdog_irq_o[0]);
      repeat (60) @(posedge clk_i);
      chkb("starved", 1'b1, wdog_irq_o[0]);
      wr(wa(0, W_CFG), 32'h0);
      for (int w = 1; w < NUM_WDOGS; w++)
      begin
         c0 = n_cpu;
         k0 = n_core;
         s0 = n_sys;
         wd_setup(w, 32'h14, 32'h0004_3211);
         repeat (150) @(posedge clk_i);
         wr(wa(w, W_CFG), 32'h0);
         chkb("stage irq", 1'b1, wdog_irq_o[w]);
         chkb("cpu reset", 1'b1, n_cpu > c0);
         chkb("core reset", 1'b1, n_core > k0);
         chkb("system reset", w == LP_WDOG, n_sys > s0);
         wr(wa(w, W_FEED), 32'h0);
         rd(wa(w, W_STAT));
         chk("stage", 32'h0, {30'h0, q[1:0]});
         chkb("irq fed", 1'b0, wdog_irq_o[w]);
         wr(wa(w, W_PROT), 32'h0);
         wr(wa(w, W_CFG), 32'h1);
         rd(wa(w, W_CFG));
         chk("locked cfg", WCFG_RST, q);
      end
      rst_dut(1'b1);
      s0 = n_sys;
      k0 = n_core;
      repeat (130) @(posedge clk_i);
      chkb("boot sys", 1'b1, n_sys > s0);
      chkb("boot core", 1'b1, n_core > k0);
      rd(wa(0, W_STAT));
      chkb("boot mode", 1'b1, q[WS_BOOT]);
      give_verdict();
   end
endmodule : tb_top
